// file: eoc_pkg.sv
// Package for the external oscillator mode control block.
// Assumes one 25 MHz core clock and a plain byte-wide register port.
package eoc_pkg;
  localparam logic [7:0] EOC_CTRL_ADDR = 8'hB1;
  localparam logic [7:0] EOC_CTRL_RESET = 8'h00;
  localparam int EOC_VALID_BIT = 7;
  localparam int EOC_MODE_MSB = 6;
  localparam int EOC_MODE_LSB = 4;
  localparam int EOC_RANGE_MSB = 2;
  localparam int EOC_RANGE_LSB = 0;
  localparam logic [2:0] EOC_MODE_PIN = 3'h2;
  localparam logic [2:0] EOC_MODE_PIN_DIV2 = 3'h3;
  localparam logic [2:0] EOC_MODE_XTAL = 3'h6;
  // Settling time the crystal must show steady edges before it counts as stable.
  localparam int EOC_SETTLE_US = 1000;
  localparam int EOC_CLK_MHZ = 25;
  localparam int EOC_SETTLE_CYCLES = EOC_SETTLE_US * EOC_CLK_MHZ;
  localparam int EOC_CNT_W = 16;

  // Oscillator control bundle sent to the analog block.
  typedef struct packed {
    logic ext_en;
    logic xtal_mode;
    logic rc_mode;
    logic [2:0] freq_range;
  } eoc_analog_s;
endpackage

// file: eoc_ctrl.sv
// External oscillator mode control: register, mode decode, clock selection, crystal valid.
// Assumes the analog oscillator and input pin are sampled as asynchronous levels.
`timescale 1ns/1ps
module eoc_ctrl #(
  parameter int SETTLE_CYCLES = eoc_pkg::EOC_SETTLE_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Clock source select from the internal oscillator control.
  input wire logic i_sysclk_source_sel,
  // External sources.
  input wire logic i_osc_input_pin,
  input wire logic i_ext_osc_out,
  // Outputs to the analog side and the clock mux.
  output eoc_pkg::eoc_analog_s o_analog,
  output logic o_int_osc_en,
  output logic o_ext_clk,
  output logic o_use_ext_clk
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] mode;
  logic [2:0] range;
  logic [2:0] next_mode;
  logic [2:0] next_range;
  logic [2:0] pin_sync;
  logic [2:0] osc_sync;
  logic pin_lvl;
  logic osc_lvl;
  logic next_pin_lvl;
  logic next_osc_lvl;
  logic div_q;
  logic next_div_q;
  logic ext_clk;
  logic next_ext_clk;
  logic [eoc_pkg::EOC_CNT_W-1:0] settle_cnt;
  logic [eoc_pkg::EOC_CNT_W-1:0] next_settle_cnt;
  logic valid;
  logic next_valid;
  logic pin_mode;
  logic div_mode;
  logic rc_mode;
  logic xtal_mode;
  logic src_lvl;
  logic src_edge;

  // Reset release through two flip-flops.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Mode decode.
  assign pin_mode = (mode == eoc_pkg::EOC_MODE_PIN) || (mode == eoc_pkg::EOC_MODE_PIN_DIV2);
  assign rc_mode = (mode[2:1] == 2'h2);
  assign xtal_mode = (mode == eoc_pkg::EOC_MODE_XTAL);
  assign div_mode = (mode == eoc_pkg::EOC_MODE_PIN_DIV2) || rc_mode;
  assign src_lvl = pin_mode ? pin_lvl : osc_lvl;
  assign src_edge = pin_mode ? (pin_sync[1] == pin_sync[2] && pin_sync[2] != pin_lvl)
                             : (osc_sync[1] == osc_sync[2] && osc_sync[2] != osc_lvl);

  // Next register, filter, divider and settle values.
  always_comb begin
    next_mode = mode;
    next_range = range;
    if (i_reg_wr && i_reg_addr == eoc_pkg::EOC_CTRL_ADDR) begin
      next_mode = i_reg_wdata[eoc_pkg::EOC_MODE_MSB:eoc_pkg::EOC_MODE_LSB];
      next_range = i_reg_wdata[eoc_pkg::EOC_RANGE_MSB:eoc_pkg::EOC_RANGE_LSB];
    end
    next_pin_lvl = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_lvl;
    next_osc_lvl = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_lvl;
    next_div_q = div_q;
    if (src_edge && src_lvl == 1'b0) begin
      next_div_q = ~div_q;
    end
    next_ext_clk = 1'b0;
    if (pin_mode || rc_mode || xtal_mode) begin
      next_ext_clk = div_mode ? div_q : src_lvl;
    end
    next_settle_cnt = settle_cnt;
    next_valid = valid;
    if (!xtal_mode) begin
      next_settle_cnt = '0;
      next_valid = 1'b0;
    end else if (src_edge && !valid) begin
      if (settle_cnt >= SETTLE_CYCLES[eoc_pkg::EOC_CNT_W-1:0] / 2) begin
        next_valid = 1'b1;
      end else begin
        next_settle_cnt = settle_cnt + 1'b1;
      end
    end
  end

  // Register stage.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= eoc_pkg::EOC_CTRL_RESET[eoc_pkg::EOC_MODE_MSB:eoc_pkg::EOC_MODE_LSB];
      range <= eoc_pkg::EOC_CTRL_RESET[eoc_pkg::EOC_RANGE_MSB:eoc_pkg::EOC_RANGE_LSB];
      pin_sync <= 3'h0;
      osc_sync <= 3'h0;
      pin_lvl <= 1'b0;
      osc_lvl <= 1'b0;
      div_q <= 1'b0;
      ext_clk <= 1'b0;
      settle_cnt <= '0;
      valid <= 1'b0;
    end else begin
      mode <= next_mode;
      range <= next_range;
      pin_sync <= {pin_sync[1:0], i_osc_input_pin};
      osc_sync <= {osc_sync[1:0], i_ext_osc_out};
      pin_lvl <= next_pin_lvl;
      osc_lvl <= next_osc_lvl;
      div_q <= next_div_q;
      ext_clk <= next_ext_clk;
      settle_cnt <= next_settle_cnt;
      valid <= next_valid;
    end
  end

  // Outputs; reset holds everything off, o_int_osc_en and o_use_ext_clk included.
  // The valid bit is masked by the crystal decode so it reads zero in the cycle the mode is left.
  assign o_reg_rdata = (i_reg_addr == eoc_pkg::EOC_CTRL_ADDR) ? {valid && xtal_mode, mode, 1'b0, range} : 8'h00;
  assign o_analog.ext_en = rst_n && (rc_mode || xtal_mode);
  assign o_analog.xtal_mode = xtal_mode;
  assign o_analog.rc_mode = rc_mode;
  assign o_analog.freq_range = range;
  assign o_int_osc_en = rst_n;
  assign o_ext_clk = ext_clk;
  assign o_use_ext_clk = rst_n && i_sysclk_source_sel;
endmodule // eoc_ctrl

// file: eoc_chk.sv
// Checker for the mode control ports.
// Assumes it is bound to eoc_ctrl and sees only its ports.
`timescale 1ns/1ps
module eoc_chk (
  // Watched ports.
  input wire logic i_clk, i_arst_n, i_reg_wr, i_sysclk_source_sel,
  input wire logic i_osc_input_pin, i_ext_osc_out, o_int_osc_en, o_ext_clk, o_use_ext_clk,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire eoc_pkg::eoc_analog_s o_analog
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Register selected and mode field as read back.
  wire sel = i_reg_addr == 8'hB1;
  wire [2:0] m = o_reg_rdata[6:4];
  sequence wr_xtal;
    i_reg_wr && sel && i_reg_wdata[6:4] == 3'h6;
  endsequence
  mode_wr_a: assert property (i_reg_wr && sel |=> m == $past(i_reg_wdata[6:4])) else $error("mode readback");
  rsvd_bit_a: assert property (o_reg_rdata[3] == 1'b0) else $error("reserved bit set");
  xtal_on_a: assert property (wr_xtal |=> o_analog.xtal_mode) else $error("crystal mode off");
  rc_dec_a: assert property (sel && m[2:1] == 2'b10 |-> o_analog.rc_mode) else $error("rc mode off");
  osc_off_a: assert property (sel && m[2:1] == 2'b00 |-> !o_analog.ext_en) else $error("osc not off");
  range_fwd_a: assert property (sel |-> o_analog.freq_range == o_reg_rdata[2:0]) else $error("range");
  valid_xtal_a: assert property (o_reg_rdata[7] |-> o_analog.xtal_mode) else $error("valid w/o crystal");
  ext_sel_a: assert property (o_use_ext_clk |-> i_sysclk_source_sel) else $error("unselected ext clock");
endmodule // eoc_chk
bind eoc_ctrl eoc_chk chk (.*);

// file: eoc_src.sv
// External clock source model: crystal, RC network or CMOS clock.
// Assumes the bench enables it; it stands low while disabled.
`timescale 1ns/1ps
module eoc_src (
  // Enable from the bench.
  input wire logic i_run,
  // Clock toward the input pin.
  output logic o_clk
);
  // Toggles every 320 ns while enabled.
  initial o_clk = 1'b0;
  always #320 o_clk = i_run ? ~o_clk : 1'b0;
endmodule // eoc_src

// file: external_oscillator_mode_control_bench.sv
// Self-checking bench for eoc_ctrl with an integer register model.
// Assumes eoc_src drives the input pin and the oscillator output.
`timescale 1ns/1ps
module external_oscillator_mode_control_bench;
  logic clk = 0, rst_n = 0, wr = 0, ssel = 0, run = 0, pin, ien, eclk, use_ext;
  logic [7:0] addr = 8'hB1, wd = 8'h00, rd, d;
  eoc_pkg::eoc_analog_s an;
  int error_cnt = 0, n_compared = 0, cyc = 0, n = 0, e;
  always #20 clk = ~clk;
  always @(posedge eclk) n++;
  eoc_src src (.i_run(run), .o_clk(pin));
  eoc_ctrl #(.SETTLE_CYCLES(8)) dut (.i_clk(clk), .i_arst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .i_sysclk_source_sel(ssel), .i_osc_input_pin(pin),
    .i_ext_osc_out(pin), .o_analog(an), .o_int_osc_en(ien), .o_ext_clk(eclk), .o_use_ext_clk(use_ext));
  task automatic cmp(string nm, logic [7:0] x, logic [7:0] s);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] v);
    @(negedge clk) addr = a;
    wd = v;
    wr = 1;
    @(negedge clk) wr = 0;
    addr = 8'hB1;
  endtask
  task end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk) if (++cyc > 6000) begin
    error_cnt++;
    end_sim;
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h8bc2));
    repeat (12) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    cmp("reset", 8'h00, rd);
    cmp("int_osc", 1, ien);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[6:4] = i;
      wr_reg(8'hB1, d);
      cmp("readback", d & 8'h77, rd);
      cmp("analog", {i == 6, i[2:1] == 2, d[2:0]}, {an.xtal_mode, an.rc_mode, an.freq_range});
      if (i < 2) cmp("ext_off", 0, an.ext_en);
    end
    wr_reg(8'hB0, 8'h25);
    addr = 8'hB0;
    @(negedge clk) cmp("unmapped", 0, rd);
    addr = 8'hB1;
    run = 1;
    for (int i = 2; i < 4; i++) begin
      wr_reg(8'hB1, i << 4);
      repeat (20) @(negedge clk);
      n = 0;
      e = 20 >> (i - 2);
      repeat (320) @(negedge clk);
      cmp("pin_rate", 1, n >= e - 1 && n <= e + 1);
    end
    wr_reg(8'hB1, 8'h67);
    repeat (300) @(negedge clk);
    cmp("valid", 8'hE7, rd);
    ssel = 1;
    @(negedge clk) cmp("use_ext", 1, use_ext);
    wr_reg(8'hB1, 8'h00);
    repeat (3) @(negedge clk);
    cmp("valid_clr", 8'h00, rd);
    rst_n = 0;
    @(negedge clk) cmp("rst_hold", 0, {ien, an.ext_en, use_ext, rd});
    end_sim;
  end
endmodule // external_oscillator_mode_control_bench
